// file: rtl/spipc_top.sv
// SPI master/slave with port S pin control, behind a plain register port.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module spipc_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic irq_out,
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe_out,
    output logic [7:0] port_pullup_out,
    output logic port_low_drive_out,
    input wire logic [1:0] sci_rx_two_wire_in,
    input wire logic [1:0] sci_tx_two_wire_in,
    input wire logic [1:0] sci_txd_in
);

    function automatic logic first_bit(input logic [7:0] data, input logic lsb_first);
        first_bit = lsb_first ? data[0] : data[7];
    endfunction : first_bit

    function automatic logic [7:0] shift_in(input logic [7:0] data, input logic bit_in,
                                            input logic lsb_first);
        shift_in = lsb_first ? {bit_in, data[7:1]} : {data[6:0], bit_in};
    endfunction : shift_in

    spipc_pkg::spipc_state_t state_ff;
    spipc_pkg::spipc_state_t nxt_state;
    spipc_pkg::spipc_drive_t drv;

    logic master;
    logic spi_enable;
    logic single;
    logic clk_idle_level;
    logic clk_phase;
    logic low_bit_first;
    logic ss_in;
    logic busy;
    logic slave_sel;
    logic rx_bit;
    logic tx_bit;
    logic [7:0] half_m1;
    logic m_tick;
    logic s_edge;
    logic edge_ev;
    logic new_lvl;
    logic leading;
    logic [7:0] sh_shifted;
    logic [7:0] port_read;
    logic [7:0] cr1_read;
    logic [7:0] sr_read;

    assign master = state_ff.cr1[spipc_pkg::SPIPC_CR1_MST];
    // A pending mode fault switches the SPI off until software recovers.
    assign spi_enable = state_ff.cr1[spipc_pkg::SPIPC_CR1_SPE] & ~state_ff.fault_flag;
    assign single = state_ff.cr2[spipc_pkg::SPIPC_CR2_SWS];
    assign clk_idle_level = state_ff.cr1[spipc_pkg::SPIPC_CR1_POL];
    assign clk_phase = state_ff.cr1[spipc_pkg::SPIPC_CR1_PHA];
    assign low_bit_first = state_ff.cr1[spipc_pkg::SPIPC_CR1_LBF];
    assign ss_in = port_pin_in[spipc_pkg::SPIPC_PIN_SS];
    assign busy = (state_ff.xfer == spipc_pkg::SPIPC_XF_RUN);
    assign slave_sel = spi_enable & ~master & ~ss_in;

    // Receive pin follows the mode: the shared pin is used in single-wire mode.
    always_comb begin
        if (master) begin
            rx_bit = single ? port_pin_in[spipc_pkg::SPIPC_PIN_MO]
                            : port_pin_in[spipc_pkg::SPIPC_PIN_SO];
        end else begin
            rx_bit = single ? port_pin_in[spipc_pkg::SPIPC_PIN_SO]
                            : port_pin_in[spipc_pkg::SPIPC_PIN_MO];
        end
    end

    // With phase set the bit is re-launched on each leading edge.
    assign tx_bit = clk_phase ? state_ff.hold : first_bit(state_ff.sh, low_bit_first);

    // Half an SCK period lasts 1 to 128 clocks for divisors 2 to 256.
    assign half_m1 = (8'd1 << state_ff.br) - 8'd1;
    assign m_tick = spi_enable & master & busy & (state_ff.div_cnt == half_m1);
    assign s_edge = slave_sel & (port_pin_in[spipc_pkg::SPIPC_PIN_SCK] != state_ff.sck_prev);
    assign edge_ev = master ? m_tick : s_edge;
    assign new_lvl = master ? ~state_ff.sck_lvl : port_pin_in[spipc_pkg::SPIPC_PIN_SCK];
    assign leading = (new_lvl != clk_idle_level);
    assign sh_shifted = shift_in(state_ff.sh, clk_phase ? rx_bit : state_ff.samp, low_bit_first);

    always_comb begin
        cr1_read = state_ff.cr1;
        cr1_read[spipc_pkg::SPIPC_CR1_SPE] = spi_enable;
        sr_read = 8'h00;
        sr_read[spipc_pkg::SPIPC_SR_DONE] = state_ff.done_flag;
        sr_read[spipc_pkg::SPIPC_SR_WRITE_CLASH_FLAG] = state_ff.clash_flag;
        sr_read[spipc_pkg::SPIPC_SR_MODE_FAULT_FLAG] = state_ff.fault_flag;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = 8'h00;
        nxt_state.sck_prev = port_pin_in[spipc_pkg::SPIPC_PIN_SCK];

        // Register reads; the answer stands only in the following cycle.
        if (reg_rd_in) begin
            case (reg_addr_in)
                spipc_pkg::SPIPC_OFS_CR1: nxt_state.rdata = cr1_read;
                spipc_pkg::SPIPC_OFS_CR2: nxt_state.rdata = state_ff.cr2;
                spipc_pkg::SPIPC_OFS_BR: nxt_state.rdata = {5'h00, state_ff.br};
                spipc_pkg::SPIPC_OFS_SR: begin
                    nxt_state.rdata = sr_read;
                    // Only flags seen set by this read may be cleared later.
                    nxt_state.arm_done = state_ff.done_flag;
                    nxt_state.arm_clash = state_ff.clash_flag;
                    nxt_state.arm_fault = state_ff.fault_flag;
                end
                spipc_pkg::SPIPC_OFS_DR: begin
                    nxt_state.rdata = state_ff.rxbuf;
                    if (state_ff.arm_done) begin
                        nxt_state.done_flag = 1'b0;
                    end
                    if (state_ff.arm_clash) begin
                        nxt_state.clash_flag = 1'b0;
                    end
                    nxt_state.arm_done = 1'b0;
                    nxt_state.arm_clash = 1'b0;
                end
                spipc_pkg::SPIPC_OFS_PORT: nxt_state.rdata = port_read;
                spipc_pkg::SPIPC_OFS_DDR: nxt_state.rdata = state_ff.ddr;
                default: nxt_state.rdata = 8'h00;
            endcase
        end

        // Register writes.
        if (reg_wr_in) begin
            case (reg_addr_in)
                spipc_pkg::SPIPC_OFS_CR1: begin
                    nxt_state.cr1 = reg_wdata_in;
                    if (state_ff.arm_fault) begin
                        nxt_state.fault_flag = 1'b0;
                    end
                    nxt_state.arm_fault = 1'b0;
                end
                spipc_pkg::SPIPC_OFS_CR2: begin
                    nxt_state.cr2 = reg_wdata_in & 8'h0d;
                end
                spipc_pkg::SPIPC_OFS_BR: nxt_state.br = reg_wdata_in[2:0];
                spipc_pkg::SPIPC_OFS_DR: begin
                    if (state_ff.arm_done) begin
                        nxt_state.done_flag = 1'b0;
                    end
                    if (state_ff.arm_clash) begin
                        nxt_state.clash_flag = 1'b0;
                    end
                    nxt_state.arm_done = 1'b0;
                    nxt_state.arm_clash = 1'b0;
                    if (busy) begin
                        // The shifter is left alone so the running byte survives.
                        nxt_state.clash_flag = 1'b1;
                    end else begin
                        nxt_state.sh = reg_wdata_in;
                        nxt_state.hold = first_bit(reg_wdata_in, low_bit_first);
                        if (spi_enable & master) begin
                            nxt_state.xfer = spipc_pkg::SPIPC_XF_RUN;
                            nxt_state.edge_cnt = 4'h0;
                            nxt_state.div_cnt = 8'h00;
                            nxt_state.sck_lvl = clk_idle_level;
                        end
                    end
                end
                spipc_pkg::SPIPC_OFS_PORT: nxt_state.latch = reg_wdata_in;
                spipc_pkg::SPIPC_OFS_DDR: nxt_state.ddr = reg_wdata_in;
                default: nxt_state.latch = nxt_state.latch;
            endcase
        end

        // Master baud divider counts only while a transfer runs.
        if (spi_enable & master & busy) begin
            if (m_tick) begin
                nxt_state.div_cnt = 8'h00;
                nxt_state.sck_lvl = ~state_ff.sck_lvl;
            end else begin
                nxt_state.div_cnt = state_ff.div_cnt + 8'd1;
            end
        end

        // Shift engine shared by master and slave.
        if (edge_ev) begin
            nxt_state.xfer = spipc_pkg::SPIPC_XF_RUN;
            nxt_state.edge_cnt = state_ff.edge_cnt + 4'd1;
            if (leading) begin
                nxt_state.samp = rx_bit;
                nxt_state.hold = first_bit(state_ff.sh, low_bit_first);
            end else begin
                nxt_state.sh = sh_shifted;
            end
            if (state_ff.edge_cnt == spipc_pkg::SPIPC_LAST_EDGE) begin
                nxt_state.rxbuf = sh_shifted;
                nxt_state.done_flag = 1'b1;
                nxt_state.xfer = spipc_pkg::SPIPC_XF_IDLE;
                nxt_state.edge_cnt = 4'h0;
            end
        end

        // A slave deselected mid-byte drops the partial transfer.
        if (~master & ss_in) begin
            nxt_state.xfer = spipc_pkg::SPIPC_XF_IDLE;
            nxt_state.edge_cnt = 4'h0;
        end

        // Mode fault; it may be set in the very cycle software clears it.
        if (state_ff.cr1[spipc_pkg::SPIPC_CR1_SPE] & master & ~ss_in
            & ~state_ff.ddr[spipc_pkg::SPIPC_PIN_SS]) begin
            nxt_state.fault_flag = 1'b1;
        end
        if (state_ff.ddr[spipc_pkg::SPIPC_PIN_SS]) begin
            nxt_state.fault_flag = 1'b0;
            nxt_state.arm_fault = 1'b0;
        end

        // Disabled or faulted: transfer state, edge and divider counts and clock level return to idle; shifter and buffer keep their bytes.
        if (~spi_enable) begin
            nxt_state.xfer = spipc_pkg::SPIPC_XF_IDLE;
            nxt_state.edge_cnt = 4'h0;
            nxt_state.div_cnt = 8'h00;
            nxt_state.sck_lvl = clk_idle_level;
        end
        if (~busy & ~(reg_wr_in & (reg_addr_in == spipc_pkg::SPIPC_OFS_DR))) begin
            nxt_state.sck_lvl = clk_idle_level;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_ff.cr1 <= spipc_pkg::SPIPC_CR1_RST;
            state_ff.cr2 <= spipc_pkg::SPIPC_CR2_RST;
            state_ff.br <= spipc_pkg::SPIPC_BR_RST;
            state_ff.ddr <= spipc_pkg::SPIPC_DDR_RST;
            state_ff.latch <= spipc_pkg::SPIPC_BYTE_RST;
            state_ff.sh <= spipc_pkg::SPIPC_BYTE_RST;
            state_ff.rxbuf <= spipc_pkg::SPIPC_BYTE_RST;
            state_ff.samp <= 1'b0;
            state_ff.hold <= 1'b0;
            state_ff.xfer <= spipc_pkg::SPIPC_XF_IDLE;
            state_ff.edge_cnt <= 4'h0;
            state_ff.div_cnt <= 8'h00;
            state_ff.sck_lvl <= 1'b0;
            state_ff.sck_prev <= 1'b0;
            state_ff.done_flag <= 1'b0;
            state_ff.clash_flag <= 1'b0;
            state_ff.fault_flag <= 1'b0;
            state_ff.arm_done <= 1'b0;
            state_ff.arm_clash <= 1'b0;
            state_ff.arm_fault <= 1'b0;
            state_ff.rdata <= 8'h00;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // SPI and SCI claims on each port S pin.
    always_comb begin
        drv.own = 8'h00;
        drv.val = 8'h00;
        drv.en = 8'h00;
        // Two-wire SCI: receive pins forced in, transmit pins forced out.
        drv.own[0] = sci_rx_two_wire_in[0];
        drv.own[1] = sci_tx_two_wire_in[0];
        drv.val[1] = sci_txd_in[0];
        drv.en[1] = 1'b1;
        drv.own[2] = sci_rx_two_wire_in[1];
        drv.own[3] = sci_tx_two_wire_in[1];
        drv.val[3] = sci_txd_in[1];
        drv.en[3] = 1'b1;
        // Bit 4: slave output; general-purpose for a single-wire master.
        drv.own[4] = spi_enable & ~(master & single);
        drv.val[4] = tx_bit;
        drv.en[4] = ~master & ~ss_in & state_ff.ddr[4];
        // Bit 5: master output; general-purpose for a single-wire slave.
        drv.own[5] = spi_enable & ~(~master & single);
        drv.val[5] = tx_bit;
        drv.en[5] = master & state_ff.ddr[5];
        // Bit 6: clock.
        drv.own[6] = spi_enable;
        drv.val[6] = state_ff.sck_lvl;
        drv.en[6] = master & state_ff.ddr[6];
        // Bit 7: slave select; a master with only direction 7 set frees it.
        drv.own[7] = spi_enable & ~(master & state_ff.ddr[7] & ~state_ff.cr1[spipc_pkg::SPIPC_CR1_SSO]);
        drv.val[7] = ~busy;
        drv.en[7] = master & state_ff.ddr[7] & state_ff.cr1[spipc_pkg::SPIPC_CR1_SSO];
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            logic val;
            logic en;
            logic od;
            assign val = drv.own[gi] ? drv.val[gi] : state_ff.latch[gi];
            assign en = drv.own[gi] ? drv.en[gi] : state_ff.ddr[gi];
            // Open-drain pins only ever pull low; a one releases the pin.
            assign od = (gi >= 4) & state_ff.cr1[spipc_pkg::SPIPC_CR1_ODS];
            assign port_pin_out[gi] = val & ~od;
            assign port_pin_oe_out[gi] = en & ~(od & val);
            assign port_pullup_out[gi] = state_ff.cr2[spipc_pkg::SPIPC_CR2_PUP] & ~en;
            assign port_read[gi] = en ? val : port_pin_in[gi];
        end
    endgenerate

    assign port_low_drive_out = state_ff.cr2[spipc_pkg::SPIPC_CR2_RDS];
    assign reg_rdata_out = state_ff.rdata;
    // The clash flag never requests an interrupt.
    assign irq_out = state_ff.cr1[spipc_pkg::SPIPC_CR1_IRQ]
                     & (state_ff.done_flag | state_ff.fault_flag);

endmodule : spipc_top

// file: rtl/spipc_pkg.sv
// Constants, types and register map for the SPI port with pin control.
package spipc_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] SPIPC_OFS_CR1 = 8'hd0;
    localparam logic [7:0] SPIPC_OFS_CR2 = 8'hd1;
    localparam logic [7:0] SPIPC_OFS_BR = 8'hd2;
    localparam logic [7:0] SPIPC_OFS_SR = 8'hd3;
    localparam logic [7:0] SPIPC_OFS_DR = 8'hd5;
    localparam logic [7:0] SPIPC_OFS_PORT = 8'hd6;
    localparam logic [7:0] SPIPC_OFS_DDR = 8'hd7;

    // Values after reset.
    localparam logic [7:0] SPIPC_CR1_RST = 8'h04;
    localparam logic [7:0] SPIPC_CR2_RST = 8'h08;
    localparam logic [2:0] SPIPC_BR_RST = 3'h0;
    localparam logic [7:0] SPIPC_DDR_RST = 8'h00;
    localparam logic [7:0] SPIPC_BYTE_RST = 8'h00;

    // Field positions in spi_control_one.
    localparam int unsigned SPIPC_CR1_IRQ = 7;
    localparam int unsigned SPIPC_CR1_SPE = 6;
    localparam int unsigned SPIPC_CR1_ODS = 5;
    localparam int unsigned SPIPC_CR1_MST = 4;
    localparam int unsigned SPIPC_CR1_POL = 3;
    localparam int unsigned SPIPC_CR1_PHA = 2;
    localparam int unsigned SPIPC_CR1_SSO = 1;
    localparam int unsigned SPIPC_CR1_LBF = 0;

    // Field positions in spi_control_two and spi_status_flags.
    localparam int unsigned SPIPC_CR2_PUP = 3;
    localparam int unsigned SPIPC_CR2_RDS = 2;
    localparam int unsigned SPIPC_CR2_SWS = 0;
    localparam int unsigned SPIPC_SR_DONE = 7;
    localparam int unsigned SPIPC_SR_WRITE_CLASH_FLAG = 6;
    localparam int unsigned SPIPC_SR_MODE_FAULT_FLAG = 4;

    // Port S pin positions used by the SPI.
    localparam int unsigned SPIPC_PIN_SO = 4;
    localparam int unsigned SPIPC_PIN_MO = 5;
    localparam int unsigned SPIPC_PIN_SCK = 6;
    localparam int unsigned SPIPC_PIN_SS = 7;

    // Sixteen SCK edges make one eight-bit transfer.
    localparam logic [3:0] SPIPC_LAST_EDGE = 4'hf;

    typedef enum logic {
        SPIPC_XF_IDLE = 1'b0,
        SPIPC_XF_RUN = 1'b1
    } spipc_xfer_t;

    typedef struct packed {
        logic [7:0] cr1;
        logic [7:0] cr2;
        logic [2:0] br;
        logic [7:0] ddr;
        logic [7:0] latch;
        logic [7:0] sh;
        logic [7:0] rxbuf;
        logic samp;
        logic hold;
        spipc_xfer_t xfer;
        logic [3:0] edge_cnt;
        logic [7:0] div_cnt;
        logic sck_lvl;
        logic sck_prev;
        logic done_flag;
        logic clash_flag;
        logic fault_flag;
        logic arm_done;
        logic arm_clash;
        logic arm_fault;
        logic [7:0] rdata;
    } spipc_state_t;

    typedef struct packed {
        logic [7:0] own;
        logic [7:0] val;
        logic [7:0] en;
    } spipc_drive_t;

endpackage : spipc_pkg

// file: test/spipc_chk.sv
// Port-level checks for the SPI port block.
`timescale 1ns/10ps
module spipc_chk (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic irq_out,
    input wire logic [7:0] port_pin_in,
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe_out,
    input wire logic [7:0] port_pullup_out,
    input wire logic [1:0] sci_rx_two_wire_in,
    input wire logic [1:0] sci_tx_two_wire_in
);
    // Control fields are shadowed from the write strobes so no internal state is needed.
    logic [7:0] cr1_ff, cr2_ff, ddr_ff;
    logic [2:0] br_ff;
    logic sck_q_ff, seen_ff, chg, ss_lo;
    logic [8:0] gap_ff;
    assign chg = port_pin_oe_out[6] && (port_pin_out[6] != sck_q_ff);
    assign ss_lo = port_pin_oe_out[7] && !port_pin_out[7];
    always_ff @(posedge clk_in) begin
        sck_q_ff <= port_pin_out[6];
        seen_ff <= !sys_rst_in && ss_lo && (seen_ff || chg);
        gap_ff <= chg ? 9'h001 : gap_ff + {8'h00, gap_ff != 9'h1ff};
        if (sys_rst_in) begin
            cr1_ff <= spipc_pkg::SPIPC_CR1_RST;
            cr2_ff <= 8'h08;
            ddr_ff <= 8'h00;
            br_ff <= 3'h0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == spipc_pkg::SPIPC_OFS_CR1) cr1_ff <= reg_wdata_in;
            if (reg_addr_in == spipc_pkg::SPIPC_OFS_CR2) cr2_ff <= reg_wdata_in & 8'h0d;
            if (reg_addr_in == spipc_pkg::SPIPC_OFS_DDR) ddr_ff <= reg_wdata_in;
            if (reg_addr_in == spipc_pkg::SPIPC_OFS_BR) br_ff <= reg_wdata_in[2:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_irq_gate: assert property (
        !cr1_ff[7] |-> !irq_out) else $error("interrupt while disabled");
    chk_dir_gate: assert property (
        (port_pin_oe_out[7:4] & ~ddr_ff[7:4]) == 4'h0) else $error("drive without direction");
    chk_sci_force: assert property (
        sci_tx_two_wire_in[1] |-> port_pin_oe_out[3] && !(sci_rx_two_wire_in[1] && port_pin_oe_out[2]))
        else $error("serial pin not forced");
    chk_pullup_dir: assert property (
        // An open-drain pin releasing a one is still an output, so its pull-up stays off.
        ((port_pullup_out ^ (cr2_ff[3] ? ~port_pin_oe_out : 8'h00))
         & (cr1_ff[5] ? 8'h0f : 8'hff)) == 8'h00
        && (port_pullup_out & port_pin_oe_out) == 8'h00) else $error("pull-up wrong");
    chk_sck_idle: assert property (
        cr1_ff[6] && cr1_ff[4] && port_pin_oe_out[6] && port_pin_oe_out[7] && port_pin_out[7]
        |-> port_pin_out[6] == cr1_ff[3]) else $error("idle clock level wrong");
    chk_sck_half: assert property (
        chg && ss_lo && seen_ff |-> gap_ff == (9'h001 << br_ff)) else $error("clock period wrong");
    chk_slave_pins: assert property (
        cr1_ff[6] && !cr1_ff[4] |-> !port_pin_oe_out[6] && !port_pin_oe_out[7])
        else $error("slave drives clock or select");
    chk_slave_out: assert property (
        (cr1_ff[6] && !cr1_ff[4] && ddr_ff[4] && !port_pin_in[7]) [*2] |-> port_pin_oe_out[4])
        else $error("selected slave not driving");
    chk_mosi_gate: assert property (
        cr1_ff[6] && cr1_ff[4] && ddr_ff[5] && ddr_ff[7] |-> port_pin_oe_out[5])
        else $error("master data pin not driven");
endmodule : spipc_chk

// file: test/spipc_peer.sv
// Behavioural far-side slave using clock format zero.
`timescale 1ns/10ps
module spipc_peer (
    input wire logic clk_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic sel_n_in,
    input wire logic [7:0] tx_byte_in,
    output logic miso_out,
    output logic miso_en_out,
    output logic [7:0] rx_byte_out
);
    logic sck_q_ff = 1'b0;
    logic [7:0] sh_ff = 8'h00;
    // Released while deselected, so the master never sees stale data.
    assign miso_en_out = !sel_n_in;
    assign miso_out = sh_ff[7];
    always @(posedge clk_in) begin
        sck_q_ff <= sck_in;
        if (sel_n_in) begin
            sh_ff <= tx_byte_in;
        end else if (sck_in && !sck_q_ff) begin
            rx_byte_out <= {rx_byte_out[6:0], mosi_in};
        end else if (!sck_in && sck_q_ff) begin
            sh_ff <= {sh_ff[6:0], !sh_ff[7]};
        end
    end
endmodule : spipc_peer

// file: test/tb.sv
// Self-checking bench for the SPI port block.
`timescale 1ns/10ps
module tb;
    logic clk_in, sys_rst_in, reg_wr_in, reg_rd_in, irq_out, peer_miso, peer_en, low_drv;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, port_pin_out, port_pin_oe_out;
    logic [7:0] port_pullup_out, pin_lvl, tb_en, tb_val, peer_tx, peer_rx;
    logic [1:0] sci_rx_two_wire_in, sci_tx_two_wire_in, sci_txd_in;
    int err_total, compares;
    spipc_top spipc_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
        .port_pin_in(pin_lvl), .port_pin_out(port_pin_out), .port_pin_oe_out(port_pin_oe_out),
        .port_pullup_out(port_pullup_out), .port_low_drive_out(low_drv),
        .sci_rx_two_wire_in(sci_rx_two_wire_in), .sci_tx_two_wire_in(sci_tx_two_wire_in),
        .sci_txd_in(sci_txd_in));
    spipc_peer spipc_peer_inst (.clk_in(clk_in), .sck_in(pin_lvl[6]), .mosi_in(pin_lvl[5]),
        .sel_n_in(pin_lvl[7]), .tx_byte_in(peer_tx), .miso_out(peer_miso),
        .miso_en_out(peer_en), .rx_byte_out(peer_rx));
    // Undriven pins settle at the pull-up level; the block wins over the bench.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (port_pin_oe_out[i]) pin_lvl[i] = port_pin_out[i];
            else if (tb_en[i]) pin_lvl[i] = tb_val[i];
            else if (i == 4 && peer_en) pin_lvl[i] = peer_miso;
            else pin_lvl[i] = port_pullup_out[i];
        end
    end
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        #1;
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        // One idle edge keeps back-to-back writes from driving the strobe twice at once.
        @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
        @(posedge clk_in);
    endtask : rd
    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = b[7 - i];
        return r;
    endfunction : rev8
    task automatic t_reset();
        logic [7:0] v;
        logic [7:0] ofs [6] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd7, 8'hd4};
        logic [7:0] exp [6] = '{spipc_pkg::SPIPC_CR1_RST, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], v);
            chk("reset register", v, exp[i]);
        end
        chk("reset enables", port_pin_oe_out, 8'h00);
        chk("reset pull-ups", port_pullup_out, 8'hff);
        wr(spipc_pkg::SPIPC_OFS_CR2, 8'hff);
        wr(8'hd4, 8'hff);
        rd(spipc_pkg::SPIPC_OFS_CR2, v);
        chk("control two", v, 8'h0d);
        chk("low drive", {7'h00, low_drv}, 8'h01);
        wr(spipc_pkg::SPIPC_OFS_CR2, 8'h08);
    endtask : t_reset
    task automatic t_port();
        logic [7:0] v;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'h0f);
        wr(spipc_pkg::SPIPC_OFS_PORT, 8'h5a);
        tb_en <= 8'hf0;
        tb_val <= 8'h90;
        rd(spipc_pkg::SPIPC_OFS_PORT, v);
        chk("port read", v, 8'h9a);
        chk("port levels", port_pin_out & 8'h0f, 8'h0a);
        sci_rx_two_wire_in <= 2'b11;
        sci_tx_two_wire_in <= 2'b11;
        sci_txd_in <= 2'b10;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'h05);
        wr(spipc_pkg::SPIPC_OFS_PORT, 8'h00);
        chk("two-wire enables", port_pin_oe_out & 8'h0f, 8'h0a);
        chk("two-wire levels", port_pin_out & 8'h0a, 8'h08);
        sci_rx_two_wire_in <= 2'b00;
        sci_tx_two_wire_in <= 2'b00;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'hf5);
        wr(spipc_pkg::SPIPC_OFS_PORT, 8'h50);
        wr(spipc_pkg::SPIPC_OFS_CR1, 8'h20);
        chk("open-drain enables", port_pin_oe_out & 8'hf0, 8'ha0);
        chk("open-drain levels", port_pin_out & 8'hf0, 8'h00);
        tb_en <= 8'h00;
    endtask : t_port
    task automatic t_slave();
        logic [7:0] v;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'hd0);
        wr(spipc_pkg::SPIPC_OFS_CR1, 8'h40);
        tb_en <= 8'h80;
        tb_val <= 8'h00;
        rd(spipc_pkg::SPIPC_OFS_SR, v);
        chk("selected slave", port_pin_oe_out & 8'hd0, 8'h10);
        tb_val <= 8'h80;
        rd(spipc_pkg::SPIPC_OFS_SR, v);
        chk("idle slave", port_pin_oe_out & 8'hd0, 8'h00);
    endtask : t_slave
    task automatic t_fault();
        logic [7:0] v;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'h00);
        wr(spipc_pkg::SPIPC_OFS_CR1, 8'hd0);
        tb_val <= 8'h00;
        wr(spipc_pkg::SPIPC_OFS_BR, 8'h00);
        wr(spipc_pkg::SPIPC_OFS_CR1, 8'hd0);
        rd(spipc_pkg::SPIPC_OFS_SR, v);
        chk("fault flag", v & 8'h10, 8'h10);
        chk("fault interrupt", {7'h00, irq_out}, 8'h01);
        rd(spipc_pkg::SPIPC_OFS_CR1, v);
        chk("enable in fault", v, 8'h90);
        tb_val <= 8'h80;
        wr(spipc_pkg::SPIPC_OFS_CR1, 8'hd0);
        rd(spipc_pkg::SPIPC_OFS_SR, v);
        chk("fault cleared", v, 8'h00);
        tb_en <= 8'h00;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'h80);
        rd(spipc_pkg::SPIPC_OFS_SR, v);
        chk("fault inhibited", v, 8'h00);
    endtask : t_fault
    task automatic t_master(input logic lsb, input logic [7:0] d, input logic [7:0] tx);
        logic [7:0] s;
        int n;
        peer_tx <= tx;
        wr(spipc_pkg::SPIPC_OFS_DDR, 8'he0);
        wr(spipc_pkg::SPIPC_OFS_BR, 8'h02);
        wr(spipc_pkg::SPIPC_OFS_CR1, {7'h69, lsb});
        wr(spipc_pkg::SPIPC_OFS_DR, d);
        wr(spipc_pkg::SPIPC_OFS_DR, 8'hff);
        s = 8'h00;
        for (n = 0; n < 300 && s[7] !== 1'b1; n++) rd(spipc_pkg::SPIPC_OFS_SR, s);
        if (s[7] !== 1'b1) begin
            err_total++;
            $display("Error done flag expected 1 seen 0");
            end_sim();
        end
        chk("flags after transfer", s & 8'hd0, 8'hc0);
        chk("done interrupt", {7'h00, irq_out}, 8'h01);
        chk("far side byte", peer_rx, lsb ? rev8(d) : d);
        rd(spipc_pkg::SPIPC_OFS_DR, s);
        chk("received byte", s, lsb ? rev8(tx) : tx);
        rd(spipc_pkg::SPIPC_OFS_SR, s);
        chk("flags cleared", s, 8'h00);
        chk("interrupt cleared", {7'h00, irq_out}, 8'h00);
    endtask : t_master
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        repeat (100000) @(posedge clk_in);
        err_total++;
        $display("Error run limit expected 0 seen 1");
        end_sim();
    end
    initial begin
        {err_total, compares} = '0;
        {sys_rst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {1'b1, 18'h0_0000};
        {tb_en, tb_val, peer_tx} = 24'h00_0000;
        {sci_rx_two_wire_in, sci_tx_two_wire_in, sci_txd_in} = 6'h00;
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_reset();
        t_port();
        t_slave();
        t_fault();
        t_master(1'b0, 8'ha5, 8'h3c);
        t_master(1'b1, 8'h13, 8'h71);
        end_sim();
    end
endmodule : tb
bind spipc_top spipc_chk spipc_chk_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .irq_out(irq_out), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe_out(port_pin_oe_out), .port_pullup_out(port_pullup_out),
    .sci_rx_two_wire_in(sci_rx_two_wire_in), .sci_tx_two_wire_in(sci_tx_two_wire_in));
